//--- rtl/pssm_pkg.sv
// Constants, types and helpers shared by the strap and mode steering block
package pssm_pkg;

    localparam int PORTS   = 4;
    localparam int NIB_W   = 4;
    localparam int IDX_W   = 2;
    localparam int PORT_A  = 0;
    localparam int PORT_B  = 1;

    // Positions of the three strap pins within the pin vector
    localparam int STRAP_SHARED_POS = 1;
    localparam int STRAP_ENH_POS    = 2;
    localparam int STRAP_SPEED_POS  = 3;

    // Values held before the straps are latched
    localparam logic STRAP_SPEED_RESET  = 1'b1;
    localparam logic STRAP_ENH_RESET    = 1'b0;
    localparam logic STRAP_SHARED_RESET = 1'b0;

    // Strap settling time after reset release
    localparam int CLK_PERIOD_NS       = 100;
    localparam int STRAP_SETTLE_NS     = 400;
    localparam int STRAP_SETTLE_CYCLES = ((STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1
                                         ? 1
                                         : (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W            = 3;
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(STRAP_SETTLE_CYCLES - 1);

    localparam logic [NIB_W-1:0] JAM_NIBBLE = 4'h5;

    localparam int BUF_DEPTH = 2;
    localparam int FILL_W    = 2;

    typedef enum logic {
        PH_SETTLE,
        PH_RUN
    } pssm_phase_type;

    // Lowest set bit: {found, index}
    function automatic logic [IDX_W:0] pssm_first_set(input logic [PORTS-1:0] v);
        logic [IDX_W:0] r;
        r = '0;
        for (int i = PORTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction : pssm_first_set

    function automatic logic [NIB_W-1:0] pssm_nib(input logic [PORTS*NIB_W-1:0] v,
                                                  input logic [IDX_W-1:0]       idx);
        return v[idx*NIB_W +: NIB_W];
    endfunction : pssm_nib

endpackage : pssm_pkg

//--- rtl/pssm_pair_buffer.sv
// Two-entry valid/ready buffer on the shared high-rate receive path
`timescale 1ns/1ps
module pssm_pair_buffer
    import pssm_pkg::*;
#(
    parameter int WIDTH = NIB_W,
    parameter int DEPTH = BUF_DEPTH
)(
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              in_valid,
    input  wire logic [WIDTH-1:0]  in_data,
    output logic                   in_ready,
    output logic                   out_valid,
    output logic [WIDTH-1:0]       out_data,
    input  wire logic              out_ready,
    output logic [FILL_W-1:0]      fill
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [FILL_W-1:0]           fill;
        logic                        ready;
    } pssm_buf_state_type;

    pssm_buf_state_type s_reg;
    pssm_buf_state_type s_next;

    always_comb begin
        logic              push;
        logic              pop;
        logic [FILL_W-1:0] wr_idx;
        s_next = s_reg;
        push   = in_valid & s_reg.ready;
        pop    = out_ready & (s_reg.fill != '0);
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                s_next.mem[i] = s_reg.mem[i+1];
            end
        end
        wr_idx = s_reg.fill - FILL_W'(pop);
        if (push) begin
            s_next.mem[wr_idx] = in_data;
        end
        s_next.fill  = s_reg.fill + FILL_W'(push) - FILL_W'(pop);
        s_next.ready = s_next.fill < FILL_W'(DEPTH);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_reg       <= '0;
            s_reg.ready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign in_ready  = s_reg.ready;
    assign out_valid = s_reg.fill != '0;
    assign out_data  = s_reg.mem[0];
    assign fill      = s_reg.fill;

endmodule : pssm_pair_buffer

//--- rtl/pssm_steering.sv
// Strap sampling, rate indicators and mode steering for the four-port transceiver
`timescale 1ns/1ps
module pssm_steering
    import pssm_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     reset,
    input  wire logic [3:1]               rate_indicator_pin,
    output logic [PORTS-1:0]              rate_indicator,
    output logic [PORTS-1:0]              rate_indicator_oe,
    input  wire logic                     autoneg_enable,
    input  wire logic                     reg_speed_select,
    input  wire logic [PORTS-1:0]         an_resolved_100,
    input  wire logic [PORTS-1:0]         low_rate_transmit_gate,
    input  wire logic [PORTS-1:0]         high_rate_transmit_gate,
    input  wire logic [PORTS*NIB_W-1:0]   mii_tx_data,
    output logic [PORTS*NIB_W-1:0]        line_tx_data,
    output logic [PORTS-1:0]              line_tx_en,
    output logic [PORTS-1:0]              line_tx_jam,
    input  wire logic [PORTS-1:0]         core_crs,
    input  wire logic [PORTS-1:0]         core_col,
    output logic [PORTS-1:0]              high_rate_carrier_sense,
    output logic [PORTS-1:0]              high_rate_collision,
    output logic [PORTS-1:0]              low_rate_carrier_sense,
    output logic [PORTS-1:0]              low_rate_collision,
    input  wire logic [PORTS*NIB_W-1:0]   core_rx_data,
    input  wire logic [PORTS-1:0]         core_rx_valid,
    output logic [PORTS-1:0]              core_rx_ready,
    output logic [PORTS*NIB_W-1:0]        mii_rx_data,
    output logic [PORTS-1:0]              mii_rx_dv,
    output logic                          high_rate_receive_gate,
    output logic                          low_rate_receive_gate,
    input  wire logic                     shared_rx_ready,
    output logic                          enhanced_mode,
    output logic                          shared_bus_mode,
    output logic                          strap_speed_100
);

    typedef struct packed {
        logic [3:1]               sync1;
        logic [3:1]               sync2;
        pssm_phase_type           phase;
        logic [SETTLE_W-1:0]      settle_cnt;
        logic                     strap_speed;
        logic                     strap_enh;
        logic                     strap_shared;
        logic [PORTS-1:0]         ind;
        logic [PORTS-1:0]         ind_oe;
        logic [PORTS*NIB_W-1:0]   tx_data;
        logic [PORTS-1:0]         tx_en;
        logic [PORTS-1:0]         tx_jam;
        logic [PORTS-1:0]         hr_crs;
        logic [PORTS-1:0]         hr_col;
        logic [PORTS-1:0]         lr_crs;
        logic [PORTS-1:0]         lr_col;
        logic [PORTS*NIB_W-1:0]   rx_data;
        logic [PORTS-1:0]         rx_dv;
        logic [PORTS-1:0]         rx_ready;
        logic                     hr_busy;
        logic [IDX_W-1:0]         hr_grant;
        logic                     lr_busy;
        logic [IDX_W-1:0]         lr_grant;
        logic                     hr_gate;
        logic                     lr_gate;
    } pssm_state_type;

    pssm_state_type s_reg;
    pssm_state_type s_next;

    logic [PORTS-1:0]  port_100;
    logic [PORTS-1:0]  security;
    logic              hr_push;
    logic              hr_pop;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic [NIB_W-1:0]  buf_out_data;
    logic [FILL_W-1:0] buf_fill;

    // Autonegotiation overrides the strap; otherwise strap AND register bit
    assign port_100 = autoneg_enable ? an_resolved_100
                    : {PORTS{s_reg.strap_speed & reg_speed_select}};
    // Security only exists in enhanced mode
    assign security = low_rate_transmit_gate & {PORTS{s_reg.strap_enh}};

    // Push only when the core saw ready, so both ends agree on the transfer
    assign hr_push = s_reg.strap_shared & s_reg.hr_busy
                   & core_rx_valid[s_reg.hr_grant]
                   & s_reg.rx_ready[s_reg.hr_grant] & buf_in_ready;
    assign hr_pop  = s_reg.strap_shared & buf_out_valid & shared_rx_ready;

    pssm_pair_buffer #(
        .WIDTH (NIB_W),
        .DEPTH (BUF_DEPTH)
    ) u_hr_buffer (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_valid  (hr_push),
        .in_data   (pssm_nib(core_rx_data, s_reg.hr_grant)),
        .in_ready  (buf_in_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_data),
        .out_ready (shared_rx_ready & s_reg.strap_shared),
        .fill      (buf_fill)
    );

    always_comb begin
        logic [IDX_W:0]    hr_pick;
        logic [IDX_W:0]    lr_pick;
        logic [FILL_W-1:0] fill_next;
        logic              lr_take;
        s_next  = s_reg;
        hr_pick = pssm_first_set(core_rx_valid & port_100);
        lr_pick = pssm_first_set(core_rx_valid & ~port_100);

        // Strap capture; the pins stay undriven until the values are held
        s_next.sync1 = rate_indicator_pin;
        s_next.sync2 = s_reg.sync1;
        case (s_reg.phase)
            PH_SETTLE: begin
                if (s_reg.settle_cnt == SETTLE_LAST) begin
                    s_next.strap_speed  = s_reg.sync2[STRAP_SPEED_POS];
                    s_next.strap_enh    = s_reg.sync2[STRAP_ENH_POS];
                    s_next.strap_shared = s_reg.sync2[STRAP_SHARED_POS];
                    s_next.phase        = PH_RUN;
                    s_next.ind_oe       = '1;
                end else begin
                    s_next.settle_cnt = s_reg.settle_cnt + SETTLE_W'(1);
                end
            end
            PH_RUN: begin
                s_next.ind_oe = '1;
            end
            default: begin
                s_next.phase = PH_SETTLE;
            end
        endcase

        s_next.ind = port_100;

        // Transmit steering
        for (int p = 0; p < PORTS; p++) begin
            if (s_reg.strap_shared) begin
                s_next.tx_data[p*NIB_W +: NIB_W] = port_100[p]
                    ? mii_tx_data[PORT_A*NIB_W +: NIB_W]
                    : mii_tx_data[PORT_B*NIB_W +: NIB_W];
            end else begin
                s_next.tx_data[p*NIB_W +: NIB_W] = mii_tx_data[p*NIB_W +: NIB_W];
            end
            s_next.tx_en[p] = port_100[p] ? high_rate_transmit_gate[p]
                            : (low_rate_transmit_gate[p] & ~s_reg.strap_enh);
            s_next.tx_jam[p] = security[p];
            if (security[p]) begin
                s_next.tx_data[p*NIB_W +: NIB_W] = JAM_NIBBLE;
                s_next.tx_en[p]                  = 1'b1;
            end
        end

        // Carrier and collision; enhanced merges both rates on the high-rate pins
        if (s_reg.strap_enh) begin
            s_next.hr_crs = core_crs;
            s_next.hr_col = core_col;
        end else begin
            s_next.hr_crs = core_crs & port_100;
            s_next.hr_col = core_col & port_100;
        end
        s_next.lr_crs = core_crs & ~port_100;
        s_next.lr_col = core_col & ~port_100;

        // Receive steering
        fill_next = buf_fill + FILL_W'(hr_push) - FILL_W'(hr_pop);
        lr_take   = s_reg.lr_busy & core_rx_valid[s_reg.lr_grant]
                  & s_reg.rx_ready[s_reg.lr_grant];
        if (!s_reg.strap_shared) begin
            s_next.rx_data  = core_rx_data;
            s_next.rx_dv    = core_rx_valid;
            s_next.rx_ready = '1;
            s_next.hr_busy  = 1'b0;
            s_next.lr_busy  = 1'b0;
            s_next.hr_gate  = 1'b0;
            s_next.lr_gate  = 1'b0;
        end else begin
            // A grant holds for the whole frame so streams never interleave
            if (s_reg.hr_busy && !core_rx_valid[s_reg.hr_grant]) begin
                s_next.hr_busy = 1'b0;
            end else if (!s_reg.hr_busy && hr_pick[IDX_W]) begin
                s_next.hr_busy  = 1'b1;
                s_next.hr_grant = hr_pick[IDX_W-1:0];
            end
            if (s_reg.lr_busy && !core_rx_valid[s_reg.lr_grant]) begin
                s_next.lr_busy = 1'b0;
            end else if (!s_reg.lr_busy && lr_pick[IDX_W]) begin
                s_next.lr_busy  = 1'b1;
                s_next.lr_grant = lr_pick[IDX_W-1:0];
            end
            // The serial path has no back-pressure; the high-rate path stalls on the buffer
            for (int p = 0; p < PORTS; p++) begin
                s_next.rx_ready[p] =
                    (s_next.hr_busy && s_next.hr_grant == IDX_W'(p)
                     && fill_next < FILL_W'(BUF_DEPTH))
                    || (s_next.lr_busy && s_next.lr_grant == IDX_W'(p));
            end
            s_next.rx_data = '0;
            s_next.rx_dv   = '0;
            s_next.rx_data[PORT_A*NIB_W +: NIB_W] = buf_out_data;
            s_next.rx_dv[PORT_A]                  = hr_pop;
            s_next.rx_data[PORT_B*NIB_W +: NIB_W] =
                pssm_nib(core_rx_data, s_reg.lr_grant);
            s_next.rx_dv[PORT_B]                  = lr_take;
            s_next.hr_gate                        = hr_pop;
            s_next.lr_gate                        = lr_take;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_reg              <= '0;
            s_reg.phase        <= PH_SETTLE;
            s_reg.strap_speed  <= STRAP_SPEED_RESET;
            s_reg.strap_enh    <= STRAP_ENH_RESET;
            s_reg.strap_shared <= STRAP_SHARED_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rate_indicator          = s_reg.ind;
    assign rate_indicator_oe       = s_reg.ind_oe;
    assign line_tx_data            = s_reg.tx_data;
    assign line_tx_en              = s_reg.tx_en;
    assign line_tx_jam             = s_reg.tx_jam;
    assign high_rate_carrier_sense = s_reg.hr_crs;
    assign high_rate_collision     = s_reg.hr_col;
    assign low_rate_carrier_sense  = s_reg.lr_crs;
    assign low_rate_collision      = s_reg.lr_col;
    assign core_rx_ready           = s_reg.rx_ready;
    assign mii_rx_data             = s_reg.rx_data;
    assign mii_rx_dv               = s_reg.rx_dv;
    assign high_rate_receive_gate  = s_reg.hr_gate;
    assign low_rate_receive_gate   = s_reg.lr_gate;
    assign enhanced_mode           = s_reg.strap_enh;
    assign shared_bus_mode         = s_reg.strap_shared;
    assign strap_speed_100         = s_reg.strap_speed;

    // Checks
    AST_IND_FOLLOWS_SPEED: assert property (@(posedge ref_clk) disable iff (reset)
        1'b1 |=> rate_indicator == $past(port_100))
        else $error("rate indicator does not follow port speed");

    AST_SPEED_AND: assert property (@(posedge ref_clk) disable iff (reset)
        !autoneg_enable |=> rate_indicator == {PORTS{$past(s_reg.strap_speed
                                                  & reg_speed_select)}})
        else $error("effective speed is not strap AND register bit");

    AST_AN_OVERRIDE: assert property (@(posedge ref_clk) disable iff (reset)
        autoneg_enable |=> rate_indicator == $past(an_resolved_100))
        else $error("speed strap affected autonegotiated speed");

    AST_STRAP_HELD: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.phase == PH_RUN |=> $stable({s_reg.strap_speed, s_reg.strap_enh,
                                           s_reg.strap_shared}) && rate_indicator_oe == '1)
        else $error("strap changed or pin released after latch");

    AST_SETTLE_LENGTH: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(s_reg.phase == PH_RUN) |-> $past(s_reg.settle_cnt) == SETTLE_LAST
                                         && strap_speed_100 == $past(s_reg.sync2[3], 1))
        else $error("strap latched at wrong time or value");

    AST_NO_DRIVE_SETTLE: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.phase == PH_SETTLE |-> rate_indicator_oe == '0)
        else $error("indicator driven while strap is sampled");

    AST_JAM: assert property (@(posedge ref_clk) disable iff (reset)
        enhanced_mode && low_rate_transmit_gate[0] |=>
            line_tx_jam[0] && line_tx_en[0] && line_tx_data[NIB_W-1:0] == JAM_NIBBLE)
        else $error("security did not force jam");

    AST_MERGED_CRS: assert property (@(posedge ref_clk) disable iff (reset)
        enhanced_mode ##1 enhanced_mode |-> high_rate_carrier_sense == $past(core_crs)
                                          && high_rate_collision == $past(core_col))
        else $error("carrier or collision not merged in enhanced mode");

    AST_SHARED_A: assert property (@(posedge ref_clk) disable iff (reset)
        hr_pop |=> mii_rx_dv[PORT_A] && high_rate_receive_gate
                   && mii_rx_data[NIB_W-1:0] == $past(buf_out_data))
        else $error("shared high-rate word not presented on port A");

    AST_SHARED_B: assert property (@(posedge ref_clk) disable iff (reset)
        shared_bus_mode |=> mii_rx_dv[3:2] == 2'h0)
        else $error("shared mode left data on ports C or D");

    AST_SHARED_OFF: assert property (@(posedge ref_clk) disable iff (reset)
        !shared_bus_mode |-> !high_rate_receive_gate && !low_rate_receive_gate)
        else $error("receive gates active outside shared mode");

    COV_JAM:       cover property (@(posedge ref_clk) disable iff (reset) |line_tx_jam);
    COV_SHARED_A:  cover property (@(posedge ref_clk) disable iff (reset)
        hr_push ##1 hr_push ##1 !hr_pop);
    COV_SHARED_B:  cover property (@(posedge ref_clk) disable iff (reset) low_rate_receive_gate);
    COV_STRAP_10:  cover property (@(posedge ref_clk) disable iff (reset)
        $rose(s_reg.phase == PH_RUN) && !strap_speed_100);

endmodule : pssm_steering

//--- sim/pssm_ctrl_model.sv
// Controller model: shared receive lane sink with stall control
`timescale 1ns/1ps
module pssm_ctrl_model
    import pssm_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    input  wire logic                   stall,
    input  wire logic [PORTS*NIB_W-1:0] mii_rx_data,
    input  wire logic [PORTS-1:0]       mii_rx_dv,
    input  wire logic                   high_rate_receive_gate,
    output logic                        shared_rx_ready,
    output logic [15:0]                 rx_words,
    output logic [7:0]                  rx_count,
    output logic [7:0]                  gate_miss
);
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            shared_rx_ready <= 1'b0;
            rx_words        <= 16'h0000;
            rx_count        <= 8'h00;
            gate_miss       <= 8'h00;
        end else begin
            shared_rx_ready <= ~stall;
            // Every port A word counts as received; one without the shared gate also counts as a gate miss
            if (mii_rx_dv[PORT_A]) begin
                rx_words <= {rx_words[11:0], mii_rx_data[3:0]};
                rx_count <= rx_count + 8'h01;
                if (!high_rate_receive_gate) begin
                    gate_miss <= gate_miss + 8'h01;
                end
            end
        end
    end
endmodule : pssm_ctrl_model

//--- sim/tb_top.sv
// Self-checking bench for the strap and mode steering block
`timescale 1ns/1ps
module tb_top;
    import pssm_pkg::*;
    logic ref_clk, reset, autoneg_enable, reg_speed_select, stall;
    logic [3:1] rate_indicator_pin;
    logic [3:0] rate_indicator, rate_indicator_oe, an_resolved_100, low_rate_transmit_gate;
    logic [3:0] high_rate_transmit_gate, line_tx_en, line_tx_jam, core_crs, core_col;
    logic [3:0] high_rate_carrier_sense, high_rate_collision, low_rate_carrier_sense;
    logic [3:0] low_rate_collision, core_rx_valid, core_rx_ready, mii_rx_dv;
    logic [15:0] mii_tx_data, line_tx_data, core_rx_data, mii_rx_data, rx_words;
    logic high_rate_receive_gate, low_rate_receive_gate, shared_rx_ready;
    logic enhanced_mode, shared_bus_mode, strap_speed_100;
    logic [7:0] rx_count, gate_miss;
    int failures = 0;
    int cmp_count = 0;

    pssm_steering i_pssm_steering (.ref_clk(ref_clk), .reset(reset),
        .rate_indicator_pin(rate_indicator_pin), .rate_indicator(rate_indicator),
        .rate_indicator_oe(rate_indicator_oe), .autoneg_enable(autoneg_enable),
        .reg_speed_select(reg_speed_select), .an_resolved_100(an_resolved_100),
        .low_rate_transmit_gate(low_rate_transmit_gate),
        .high_rate_transmit_gate(high_rate_transmit_gate), .mii_tx_data(mii_tx_data),
        .line_tx_data(line_tx_data), .line_tx_en(line_tx_en), .line_tx_jam(line_tx_jam),
        .core_crs(core_crs), .core_col(core_col),
        .high_rate_carrier_sense(high_rate_carrier_sense),
        .high_rate_collision(high_rate_collision),
        .low_rate_carrier_sense(low_rate_carrier_sense),
        .low_rate_collision(low_rate_collision), .core_rx_data(core_rx_data),
        .core_rx_valid(core_rx_valid), .core_rx_ready(core_rx_ready),
        .mii_rx_data(mii_rx_data), .mii_rx_dv(mii_rx_dv),
        .high_rate_receive_gate(high_rate_receive_gate),
        .low_rate_receive_gate(low_rate_receive_gate), .shared_rx_ready(shared_rx_ready),
        .enhanced_mode(enhanced_mode), .shared_bus_mode(shared_bus_mode),
        .strap_speed_100(strap_speed_100));

    pssm_ctrl_model i_pssm_ctrl_model (.ref_clk(ref_clk), .reset(reset), .stall(stall),
        .mii_rx_data(mii_rx_data), .mii_rx_dv(mii_rx_dv),
        .high_rate_receive_gate(high_rate_receive_gate), .shared_rx_ready(shared_rx_ready),
        .rx_words(rx_words), .rx_count(rx_count), .gate_miss(gate_miss));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // Straps are applied during reset, then the pins are flipped to show they no longer matter
    task automatic strap_reset(input logic [3:1] p);
        reset <= 1'b1;
        rate_indicator_pin <= p;
        repeat (3) @(posedge ref_clk);
        check("oe_in_reset", 16'h0000, {12'h000, rate_indicator_oe});
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rate_indicator_pin <= ~p;
        repeat (4) @(posedge ref_clk);
        check("oe_run", 16'h000F, {12'h000, rate_indicator_oe});
        check("straps", {13'h0000, p[2], p[1], p[3]},
              {13'h0000, enhanced_mode, shared_bus_mode, strap_speed_100});
        $display("strap reset %b done", p);
    endtask : strap_reset

    task automatic test_speed;
        strap_reset(3'b100);
        check("ind_default", 16'h000F, {12'h000, rate_indicator});
        reg_speed_select <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("ind_reg_low", 16'h0000, {12'h000, rate_indicator});
        autoneg_enable <= 1'b1;
        an_resolved_100 <= 4'h5;
        repeat (4) @(posedge ref_clk);
        check("ind_autoneg", 16'h0005, {12'h000, rate_indicator});
        autoneg_enable <= 1'b0;
        reg_speed_select <= 1'b1;
        strap_reset(3'b000);
        core_crs <= 4'hA;
        repeat (4) @(posedge ref_clk);
        check("ind_strap_low", 16'h0000, {12'h000, rate_indicator});
        check("crs_low_rate", 16'h000A, {12'h000, low_rate_carrier_sense});
        check("crs_high_rate", 16'h0000, {12'h000, high_rate_carrier_sense});
        $display("speed test done");
    endtask : test_speed

    task automatic test_enhanced;
        strap_reset(3'b110);
        mii_tx_data <= 16'h1234;
        high_rate_transmit_gate <= 4'h3;
        low_rate_transmit_gate <= 4'h1;
        core_crs <= 4'hA;
        core_col <= 4'h6;
        repeat (4) @(posedge ref_clk);
        check("jam", 16'h0001, {12'h000, line_tx_jam});
        check("tx_en", 16'h0003, {12'h000, line_tx_en});
        check("tx_data", {8'h00, 4'h3, JAM_NIBBLE}, {8'h00, line_tx_data[7:0]});
        check("crs_merged", 16'h000A, {12'h000, high_rate_carrier_sense});
        check("col_merged", 16'h0006, {12'h000, high_rate_collision});
        low_rate_transmit_gate <= 4'h0;
        core_crs <= 4'h0;
        core_col <= 4'h0;
        $display("enhanced test done");
    endtask : test_enhanced

    // Port C streams four nibbles onto the shared lane while the controller stalls first
    task automatic test_shared;
        logic [15:0] sw;
        int i;
        sw = 16'hABCD;
        i = 0;
        strap_reset(3'b101);
        stall <= 1'b1;
        core_rx_valid <= 4'h4;
        core_rx_data <= {4'h0, sw[15:12], 8'h00};
        for (int n = 0; n < 60 && i < 4; n++) begin
            @(posedge ref_clk);
            if (core_rx_ready[2] === 1'b1) i++;
            if (n == 8) stall <= 1'b0;
            if (i < 4) core_rx_data[11:8] <= sw[15-4*i -: 4];
        end
        core_rx_valid <= 4'h0;
        repeat (10) @(posedge ref_clk);
        check("sent", 16'h0004, 16'(i));
        check("rx_count", 16'h0004, {8'h00, rx_count});
        check("rx_words", sw, rx_words);
        check("gate_miss", 16'h0000, {8'h00, gate_miss});
        // Port D resolved to the low rate streams onto the port B lane
        an_resolved_100 <= 4'h7;
        autoneg_enable <= 1'b1;
        core_rx_valid <= 4'h8;
        core_rx_data <= 16'h9000;
        core_col <= 4'h8;
        repeat (4) @(posedge ref_clk);
        check("lr_gate", 16'h0001, {15'h0000, low_rate_receive_gate});
        check("lr_dv", 16'h0002, {12'h000, mii_rx_dv});
        check("lr_data", 16'h0009, {12'h000, mii_rx_data[7:4]});
        check("lr_col", 16'h0008, {12'h000, low_rate_collision});
        core_rx_valid <= 4'h0;
        autoneg_enable <= 1'b0;
        core_col <= 4'h0;
        $display("shared test done");
    endtask : test_shared

    initial begin
        reset = 1'b1;
        rate_indicator_pin = 3'b100;
        autoneg_enable = 1'b0;
        reg_speed_select = 1'b1;
        an_resolved_100 = 4'h0;
        low_rate_transmit_gate = 4'h0;
        high_rate_transmit_gate = 4'h0;
        mii_tx_data = 16'h0000;
        core_crs = 4'h0;
        core_col = 4'h0;
        core_rx_data = 16'h0000;
        core_rx_valid = 4'h0;
        stall = 1'b0;
        test_speed();
        test_enhanced();
        test_shared();
        give_verdict();
    end

    // Whole run needs well under 300 cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end
endmodule : tb_top
